// ==== src/clk_out_pkg.sv ====
package clk_out_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int DATA_W   = 32;
  localparam int REG_W    = 8;
  localparam int ADDR_W   = 10;
  localparam int SRC_N    = 4;

  // ************************************************************
  // Register map: printed offsets are indices, byte address is 4x
  // ************************************************************
  localparam logic [7:0]        IDX_CONTROL  = 8'h25;
  localparam logic [7:0]        IDX_DIVIDER  = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DIVIDER = {IDX_DIVIDER, 2'h0};
  localparam int                LANE0        = 0;

  // Reset values: selector 0, format 1, first mode 2, second mode 0
  localparam logic [REG_W-1:0] CONTROL_RESET = 8'h18;
  localparam logic [REG_W-1:0] DIVIDER_RESET = 8'h02;

  // ************************************************************
  // Encodings
  // ************************************************************
  typedef enum logic [1:0] {
    SRC_SYNTH1  = 2'h0,
    SRC_SYNTH2  = 2'h1,
    SRC_REF_PRI = 2'h2,
    SRC_REF_SEC = 2'h3
  } source_e;

  typedef enum logic [1:0] {
    FMT_OFF     = 2'h0,
    FMT_AC_DIFF = 2'h1,
    FMT_HCSL    = 2'h2,
    FMT_CMOS    = 2'h3
  } format_e;

  typedef enum logic [1:0] {
    PIN_TRISTATE = 2'h0,
    PIN_LOW      = 2'h1,
    PIN_INVERTED = 2'h2,
    PIN_NORMAL   = 2'h3
  } pin_mode_e;

  // Tail current in mA, load resistance in ohm
  localparam logic [4:0] TAIL_MA_0    = 5'h04;
  localparam logic [4:0] TAIL_MA_1    = 5'h06;
  localparam logic [4:0] TAIL_MA_2    = 5'h08;
  localparam logic [4:0] TAIL_MA_HCSL = 5'h10;
  localparam logic [7:0] LOAD_OHM_0   = 8'h00;
  localparam logic [7:0] LOAD_OHM_1   = 8'h32;
  localparam logic [7:0] LOAD_OHM_2   = 8'h64;
  localparam logic [7:0] LOAD_OHM_3   = 8'hC8;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    source_e    source_select;
    format_e    driver_format;
    logic [1:0] driver_mode_first;
    logic [1:0] driver_mode_second;
  } ctl_s;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_s;

  typedef struct packed {
    pin_s       true_pin;
    pin_s       comp_pin;
    logic [4:0] tail_ma;
    logic [7:0] load_ohm;
  } drive_s;

endpackage

// ==== src/chan_divider.sv ====
`timescale 1ns/1ps
module chan_divider #(
  parameter int DIV_W = 8
) (
  input  wire logic                         sys_clk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic [clk_out_pkg::SRC_N-1:0] src_tick_i,
  input  wire clk_out_pkg::source_e          source_select_i,
  input  wire logic [DIV_W-1:0]             div_code_i,
  output logic                              chan_tick_o,
  output logic                              chan_clk_o
);
  import clk_out_pkg::*;

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;
  logic             clk_reg;
  logic             clk_next;
  logic             sel_tick;
  logic             synth_src;

  // ************************************************************
  // Source mux and divide counter
  // ************************************************************
  // Compare with >= so a smaller code written mid-count cannot strand the counter
  always_comb begin
    sel_tick  = src_tick_i[source_select_i];
    synth_src = (source_select_i == SRC_SYNTH1) ||
                (source_select_i == SRC_SYNTH2);
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    clk_next  = clk_reg;
    if (sel_tick) begin
      if (!synth_src || (cnt_reg >= div_code_i)) begin
        cnt_next  = '0;
        tick_next = 1'b1;
        clk_next  = ~clk_reg;
      end else begin
        cnt_next  = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
      clk_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
      clk_reg  <= clk_next;
    end
  end

  assign chan_tick_o = tick_reg;
  assign chan_clk_o  = clk_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_ref_bypass;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (!synth_src && sel_tick) |=> chan_tick_o;
  endproperty
  a_ref_bypass: assert property (p_ref_bypass)
    else $error("reference tick not passed undivided");

  property p_div_hold;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (synth_src && sel_tick && (cnt_reg < div_code_i)) |=> !chan_tick_o;
  endproperty
  a_div_hold: assert property (p_div_hold)
    else $error("divided tick emitted early");

  property p_div_fire;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      (synth_src && sel_tick && (cnt_reg == div_code_i)) |=> (chan_tick_o && cnt_reg == '0);
  endproperty
  a_div_fire: assert property (p_div_fire)
    else $error("divided tick missing at terminal count");

  property p_mux_quiet;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
      !sel_tick |=> !chan_tick_o;
  endproperty
  a_mux_quiet: assert property (p_mux_quiet)
    else $error("tick from unselected source");

  c_div_by_three: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    synth_src && div_code_i == 8'h02 && chan_tick_o);
  c_ref_path: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    source_select_i == SRC_REF_SEC && chan_tick_o);

endmodule

// ==== src/drive_decode.sv ====
`timescale 1ns/1ps
module drive_decode (
  input  wire clk_out_pkg::ctl_s   ctl_i,
  input  wire logic                chan_clk_i,
  output clk_out_pkg::drive_s      drive_o
);
  import clk_out_pkg::*;

  // Single-ended pin from its two-bit power and polarity code
  function automatic pin_s cmos_pin(input logic [1:0] mode, input logic clk);
    pin_s p;
    unique case (pin_mode_e'(mode))
      PIN_TRISTATE: p = '{out: 1'b0, oe: 1'b0};
      PIN_LOW:      p = '{out: 1'b0, oe: 1'b1};
      PIN_INVERTED: p = '{out: ~clk, oe: 1'b1};
      PIN_NORMAL:   p = '{out: clk,  oe: 1'b1};
    endcase
    return p;
  endfunction

  // ************************************************************
  // Format decode
  // ************************************************************
  // Analog settings are only encoded; the pad cells interpret them
  always_comb begin
    drive_o = '0;
    unique case (ctl_i.driver_format)
      FMT_OFF: begin
        drive_o = '0;
      end
      FMT_AC_DIFF, FMT_HCSL: begin
        drive_o.true_pin = '{out: chan_clk_i,  oe: 1'b1};
        drive_o.comp_pin = '{out: ~chan_clk_i, oe: 1'b1};
        unique case (ctl_i.driver_mode_first)
          2'h0: drive_o.tail_ma = TAIL_MA_0;
          2'h1: drive_o.tail_ma = TAIL_MA_1;
          2'h2: drive_o.tail_ma = TAIL_MA_2;
          2'h3: drive_o.tail_ma = (ctl_i.driver_format == FMT_HCSL) ?
                                  TAIL_MA_HCSL : TAIL_MA_2;
        endcase
        if (ctl_i.driver_format == FMT_HCSL) begin
          unique case (ctl_i.driver_mode_second)
            2'h0: drive_o.load_ohm = LOAD_OHM_0;
            2'h1: drive_o.load_ohm = LOAD_OHM_1;
            2'h2: drive_o.load_ohm = LOAD_OHM_2;
            2'h3: drive_o.load_ohm = LOAD_OHM_3;
          endcase
        end
      end
      FMT_CMOS: begin
        drive_o.true_pin = cmos_pin(ctl_i.driver_mode_first, chan_clk_i);
        drive_o.comp_pin = cmos_pin(ctl_i.driver_mode_second, chan_clk_i);
      end
    endcase
  end

endmodule

// ==== src/clk_out_channel.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Source code 0/1/2/3 picks synth one, synth two, primary, secondary reference.
// - Format code 0 off, 1 AC differential, 2 HCSL, 3 single-ended CMOS.
// - Differential first mode: 4, 6, 8 mA; code 3 is 16 mA HCSL, else 8.
// - CMOS first mode drives true pin: tristate, low, inverted, normal.
// - Second mode: HCSL load 0/50/100/200 ohm; CMOS complement pin like true pin.
// - Divider code plus one is the ratio, 1 through 256.
// - Divider acts only on synthesizer sources; references pass undivided.
// - Divider resets to code 2 (ratio 3) and stays read/write.
module clk_out_channel #(
  parameter int DIV_W = 8
) (
  input  wire logic                            sys_clk_i,
  input  wire logic                            sys_rst_i,
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [clk_out_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic [clk_out_pkg::DATA_W-1:0]  pwdata_i,
  input  wire logic [3:0]                      pstrb_i,
  output logic      [clk_out_pkg::DATA_W-1:0]  prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  input  wire logic [clk_out_pkg::SRC_N-1:0]   src_tick_i,
  output logic                                 chan_tick_o,
  output clk_out_pkg::format_e                 format_o,
  output clk_out_pkg::drive_s                  drive_o
);
  import clk_out_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } bus_state_e;

  bus_state_e       state_reg;
  bus_state_e       state_next;
  logic             pready_reg;
  logic             pready_next;
  logic             pslverr_reg;
  logic             pslverr_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  ctl_s             ctl_reg;
  ctl_s             ctl_next;
  logic [REG_W-1:0] div_reg;
  logic [REG_W-1:0] div_next;
  drive_s           drive_reg;
  drive_s           drive_comb;
  format_e          format_reg;
  logic             hit_ctl;
  logic             hit_div;
  logic             wr_take;
  logic             div_tick;
  logic             div_clk;

  // ************************************************************
  // APB slave: one wait state, response from registers
  // ************************************************************
  // The extra cycle lets prdata and pready come straight from flops
  always_comb begin
    hit_ctl      = (paddr_i == ADDR_CONTROL);
    hit_div      = (paddr_i == ADDR_DIVIDER);
    state_next   = state_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    prdata_next  = '0;
    wr_take      = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (psel_i && penable_i) begin
          state_next   = ST_ACK;
          pready_next  = 1'b1;
          pslverr_next = !(hit_ctl || hit_div);
          if (!pwrite_i && hit_ctl) begin
            prdata_next = DATA_W'(ctl_reg);
          end else if (!pwrite_i && hit_div) begin
            prdata_next = DATA_W'(div_reg);
          end
        end
      end
      ST_ACK: begin
        state_next = ST_IDLE;
        wr_take    = psel_i && penable_i && pwrite_i && pstrb_i[LANE0];
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg   <= ST_IDLE;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      state_reg   <= state_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // A write takes effect at the edge where the master sees pready
  always_comb begin
    ctl_next = ctl_reg;
    div_next = div_reg;
    if (wr_take && hit_ctl) begin
      ctl_next = ctl_s'(pwdata_i[REG_W-1:0]);
    end
    if (wr_take && hit_div) begin
      div_next = pwdata_i[REG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctl_reg <= ctl_s'(CONTROL_RESET);
      div_reg <= DIVIDER_RESET;
    end else begin
      ctl_reg <= ctl_next;
      div_reg <= div_next;
    end
  end

  // ************************************************************
  // Channel clock path
  // ************************************************************
  chan_divider #(
    .DIV_W (DIV_W)
  ) u_divider (
    .sys_clk_i       (sys_clk_i),
    .sys_rst_i       (sys_rst_i),
    .src_tick_i      (src_tick_i),
    .source_select_i (ctl_reg.source_select),
    .div_code_i      (div_reg[DIV_W-1:0]),
    .chan_tick_o     (div_tick),
    .chan_clk_o      (div_clk)
  );

  drive_decode u_decode (
    .ctl_i      (ctl_reg),
    .chan_clk_i (div_clk),
    .drive_o    (drive_comb)
  );

  // Output stage registered so pads never see decode glitches
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      drive_reg  <= '0;
      format_reg <= FMT_OFF;
    end else begin
      drive_reg  <= drive_comb;
      format_reg <= ctl_reg.driver_format;
    end
  end

  assign prdata_o    = prdata_reg;
  assign pready_o    = pready_reg;
  assign pslverr_o   = pslverr_reg;
  assign chan_tick_o = div_tick;
  assign format_o    = format_reg;
  assign drive_o     = drive_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_div_reset;
    $past(sys_rst_i) && !sys_rst_i |-> (div_reg == DIVIDER_RESET);
  endproperty
  a_div_reset: assert property (p_div_reset)
    else $error("divider not at reset code after reset");

  property p_div_readback;
    (state_reg == ST_IDLE && psel_i && penable_i && !pwrite_i && hit_div)
      |=> (pready_o && prdata_o == DATA_W'($past(div_reg)));
  endproperty
  a_div_readback: assert property (p_div_readback)
    else $error("divider readback mismatch");

  property p_off_quiet;
    (ctl_reg.driver_format == FMT_OFF) |=> (!drive_o.true_pin.oe && !drive_o.comp_pin.oe);
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled output still driving");

  property p_diff_pair;
    (ctl_reg.driver_format == FMT_AC_DIFF || ctl_reg.driver_format == FMT_HCSL)
      |=> (drive_o.true_pin.out != drive_o.comp_pin.out) && drive_o.comp_pin.oe;
  endproperty
  a_diff_pair: assert property (p_diff_pair)
    else $error("differential pins not complementary");

  property p_tail_hcsl;
    (ctl_reg.driver_format == FMT_HCSL && ctl_reg.driver_mode_first == 2'h3)
      |=> (drive_o.tail_ma == TAIL_MA_HCSL);
  endproperty
  a_tail_hcsl: assert property (p_tail_hcsl)
    else $error("HCSL top tail current wrong");

  property p_tail_ac;
    (ctl_reg.driver_format == FMT_AC_DIFF && ctl_reg.driver_mode_first == 2'h3)
      |=> (drive_o.tail_ma == TAIL_MA_2);
  endproperty
  a_tail_ac: assert property (p_tail_ac)
    else $error("AC top tail current wrong");

  property p_cmos_true_low;
    (ctl_reg.driver_format == FMT_CMOS && ctl_reg.driver_mode_first == 2'h1)
      |=> (drive_o.true_pin.oe && !drive_o.true_pin.out);
  endproperty
  a_cmos_true_low: assert property (p_cmos_true_low)
    else $error("true pin not driven low");

  property p_cmos_comp_normal;
    (ctl_reg.driver_format == FMT_CMOS && ctl_reg.driver_mode_second == 2'h3)
      |=> (drive_o.comp_pin.oe && drive_o.comp_pin.out == $past(div_clk));
  endproperty
  a_cmos_comp_normal: assert property (p_cmos_comp_normal)
    else $error("complement pin polarity wrong");

  property p_hcsl_load;
    (ctl_reg.driver_format == FMT_HCSL && ctl_reg.driver_mode_second == 2'h2)
      |=> (drive_o.load_ohm == LOAD_OHM_2);
  endproperty
  a_hcsl_load: assert property (p_hcsl_load)
    else $error("HCSL load code wrong");

  property p_ctl_write;
    (wr_take && hit_ctl) |=> (ctl_reg == ctl_s'(REG_W'($past(pwdata_i))));
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("control write not stored");

  property p_div_write;
    (wr_take && hit_div) |=> (div_reg == REG_W'($past(pwdata_i)));
  endproperty
  a_div_write: assert property (p_div_write)
    else $error("divider write not stored");

  property p_lane_off;
    (state_reg == ST_ACK && !pstrb_i[LANE0]) |=> ($stable(div_reg) && $stable(ctl_reg));
  endproperty
  a_lane_off: assert property (p_lane_off)
    else $error("register changed with lane zero strobe low");

  property p_tail_low;
    (ctl_reg.driver_format == FMT_AC_DIFF || ctl_reg.driver_format == FMT_HCSL) &&
      (ctl_reg.driver_mode_first == 2'h0) |=> (drive_o.tail_ma == TAIL_MA_0);
  endproperty
  a_tail_low: assert property (p_tail_low)
    else $error("lowest tail current wrong");

  property p_tail_mid;
    (ctl_reg.driver_format == FMT_AC_DIFF || ctl_reg.driver_format == FMT_HCSL) &&
      (ctl_reg.driver_mode_first == 2'h1) |=> (drive_o.tail_ma == TAIL_MA_1);
  endproperty
  a_tail_mid: assert property (p_tail_mid)
    else $error("middle tail current wrong");

  property p_cmos_true_tri;
    (ctl_reg.driver_format == FMT_CMOS && ctl_reg.driver_mode_first == 2'h0)
      |=> !drive_o.true_pin.oe;
  endproperty
  a_cmos_true_tri: assert property (p_cmos_true_tri)
    else $error("true pin not released");

  property p_cmos_true_inv;
    (ctl_reg.driver_format == FMT_CMOS && ctl_reg.driver_mode_first == 2'h2)
      |=> (drive_o.true_pin.oe && drive_o.true_pin.out == !$past(div_clk));
  endproperty
  a_cmos_true_inv: assert property (p_cmos_true_inv)
    else $error("true pin not inverted");

  property p_cmos_comp_tri;
    (ctl_reg.driver_format == FMT_CMOS && ctl_reg.driver_mode_second == 2'h0)
      |=> !drive_o.comp_pin.oe;
  endproperty
  a_cmos_comp_tri: assert property (p_cmos_comp_tri)
    else $error("complement pin not released");

  property p_cmos_comp_low;
    (ctl_reg.driver_format == FMT_CMOS && ctl_reg.driver_mode_second == 2'h1)
      |=> (drive_o.comp_pin.oe && !drive_o.comp_pin.out);
  endproperty
  a_cmos_comp_low: assert property (p_cmos_comp_low)
    else $error("complement pin not driven low");

  property p_hcsl_load_low;
    (ctl_reg.driver_format == FMT_HCSL && ctl_reg.driver_mode_second == 2'h1)
      |=> (drive_o.load_ohm == LOAD_OHM_1);
  endproperty
  a_hcsl_load_low: assert property (p_hcsl_load_low)
    else $error("HCSL lowest load code wrong");

  property p_no_load_else;
    (ctl_reg.driver_format != FMT_HCSL) |=> (drive_o.load_ohm == LOAD_OHM_0);
  endproperty
  a_no_load_else: assert property (p_no_load_else)
    else $error("load code set outside HCSL");

  property p_format_hcsl;
    (ctl_reg.driver_format == FMT_HCSL) |=> (format_o == FMT_HCSL);
  endproperty
  a_format_hcsl: assert property (p_format_hcsl)
    else $error("format output does not follow control");

  c_write_div: cover property (wr_take && hit_div);
  c_cmos_mode: cover property (format_o == FMT_CMOS && drive_o.true_pin.oe);
  c_bad_addr:  cover property (pready_o && pslverr_o);

endmodule

// ==== dv/output_channel_source_and_divider_tb.sv ====
`timescale 1ns/1ps
module output_channel_source_and_divider_tb;
  import clk_out_pkg::*;

  // ************************************************************
  // Signals
  // ************************************************************
  logic                sys_clk_i   = 1'b0;
  logic                sys_rst_i   = 1'b1;
  logic                psel_i      = 1'b0;
  logic                penable_i   = 1'b0;
  logic                pwrite_i    = 1'b0;
  logic [ADDR_W-1:0]   paddr_i     = '0;
  logic [DATA_W-1:0]   pwdata_i    = '0;
  logic [3:0]          pstrb_i     = 4'h0;
  logic [SRC_N-1:0]    src_tick_i  = 4'h0;
  logic [DATA_W-1:0]   prdata_o;
  logic                pready_o;
  logic                pslverr_o;
  logic                chan_tick_o;
  format_e             format_o;
  drive_s              drive_o;
  int                  n_mismatch  = 0;
  int                  n_checks    = 0;
  int                  n_seen      = 0;
  int                  n_sel;
  int                  exp_n;
  logic                last_err;
  logic [31:0]         r;
  logic [31:0]         d;
  logic [7:0]          c;
  logic [7:0]          dv;
  logic [3:0]          t;
  logic [7:0]          exp_reg [2];
  logic [7:0]          div_tab [4] = '{8'h00, 8'h02, 8'hFF, 8'h00};

  clk_out_channel #(.DIV_W(8)) u_dut (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .psel_i      (psel_i),
    .penable_i   (penable_i),
    .pwrite_i    (pwrite_i),
    .paddr_i     (paddr_i),
    .pwdata_i    (pwdata_i),
    .pstrb_i     (pstrb_i),
    .prdata_o    (prdata_o),
    .pready_o    (pready_o),
    .pslverr_o   (pslverr_o),
    .src_tick_i  (src_tick_i),
    .chan_tick_o (chan_tick_o),
    .format_o    (format_o),
    .drive_o     (drive_o)
  );

  // 25 MHz system clock
  always #20 sys_clk_i = ~sys_clk_i;

  // Count output ticks on the falling edge, away from the launching edge
  always @(negedge sys_clk_i) begin
    if (chan_tick_o === 1'b1) begin
      n_seen++;
    end
  end

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_drive(input drive_s exp, input drive_s got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch drive_o expected %h seen %h", exp, got);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard: the full run needs roughly 20500 cycles
  initial begin
    #(40 * 60000);
    n_mismatch++;
    conclude();
  end

  // ************************************************************
  // Expected driver state, worked out from the control byte
  // ************************************************************
  function automatic pin_s exp_pin(input logic [1:0] m, input logic lvl);
    case (m)
      2'h0: return '{out: 1'b0, oe: 1'b0};
      2'h1: return '{out: 1'b0, oe: 1'b1};
      2'h2: return '{out: ~lvl, oe: 1'b1};
      default: return '{out: lvl, oe: 1'b1};
    endcase
  endfunction

  function automatic drive_s exp_drive(input logic [7:0] ctl, input logic lvl);
    drive_s e;
    e = '0;
    if (ctl[5:4] == 2'h3) begin
      e.true_pin = exp_pin(ctl[3:2], lvl);
      e.comp_pin = exp_pin(ctl[1:0], lvl);
    end else if (ctl[5:4] != 2'h0) begin
      e.true_pin = '{out: lvl, oe: 1'b1};
      e.comp_pin = '{out: ~lvl, oe: 1'b1};
      case (ctl[3:2])
        2'h0: e.tail_ma = 5'h04;
        2'h1: e.tail_ma = 5'h06;
        2'h2: e.tail_ma = 5'h08;
        default: e.tail_ma = (ctl[5:4] == 2'h2) ? 5'h10 : 5'h08;
      endcase
      if (ctl[5:4] == 2'h2) begin
        case (ctl[1:0])
          2'h0: e.load_ohm = 8'h00;
          2'h1: e.load_ohm = 8'h32;
          2'h2: e.load_ohm = 8'h64;
          default: e.load_ohm = 8'hC8;
        endcase
      end
    end
    return e;
  endfunction

  // ************************************************************
  // Bus and reset tasks
  // ************************************************************
  task automatic do_reset();
    sys_rst_i  <= 1'b1;
    src_tick_i <= 4'h0;
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
  endtask

  // Request held until pready_o is seen high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     input logic [3:0] s, output logic [31:0] rd);
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    pstrb_i   <= s;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // No local limit: a slave that never answers is caught by the hang guard
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd        = prdata_o;
    last_err  = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'h10B0A390));
    do_reset();
    apb(1'b0, ADDR_CONTROL, 32'h0, 4'h0, r);
    chk_val("control reset", 32'h00000018, r);
    apb(1'b0, ADDR_DIVIDER, 32'h0, 4'h0, r);
    chk_val("divider reset", 32'h00000002, r);
    // Read-write through both registers, upper bits must read zero
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hFFFFFF00 : (i == 1) ? 32'h000000FF : $urandom;
      apb(1'b1, i[0] ? ADDR_DIVIDER : ADDR_CONTROL, d, 4'hF, r);
      exp_reg[i % 2] = d[7:0];
      apb(1'b0, i[0] ? ADDR_DIVIDER : ADDR_CONTROL, 32'h0, 4'h0, r);
      chk_val("register readback", {24'h0, exp_reg[i % 2]}, r);
    end
    // Lane zero strobe off: the write must be dropped without error
    apb(1'b1, ADDR_DIVIDER, ~d, 4'hE, r);
    chk_val("pslverr_o", 32'h0, 32'(last_err));
    // Unmapped address: error flagged, nothing written, data zero
    apb(1'b1, ADDR_DIVIDER + 10'h004, 32'h00000055, 4'hF, r);
    chk_val("pslverr_o", 32'h1, 32'(last_err));
    apb(1'b0, ADDR_DIVIDER + 10'h004, 32'h0, 4'h0, r);
    chk_val("unmapped read", 32'h0, r);
    chk_val("pslverr_o", 32'h1, 32'(last_err));
    apb(1'b0, ADDR_DIVIDER, 32'h0, 4'h0, r);
    chk_val("divider kept", {24'h0, exp_reg[1]}, r);

    // Every format and mode code, with the channel clock low and then high
    for (int lvl = 0; lvl < 2; lvl++) begin
      do_reset();
      if (lvl == 1) begin
        apb(1'b1, ADDR_CONTROL, 32'h00000098, 4'hF, r);
        @(posedge sys_clk_i);
        src_tick_i <= 4'h4;
        @(posedge sys_clk_i);
        src_tick_i <= 4'h0;
      end
      for (int i = 0; i < 64; i++) begin
        c = {2'h2, 6'(i)};
        apb(1'b1, ADDR_CONTROL, {24'h0, c}, 4'hF, r);
        repeat (3) @(posedge sys_clk_i);
        chk_drive(exp_drive(c, 1'(lvl)), drive_o);
        chk_val("format_o", 32'(c[5:4]), 32'(format_o));
      end
    end

    // Each source with boundary and random ratios; other sources tick too
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 4; k++) begin
        dv = (k == 3) ? 8'($urandom_range(1, 254)) : div_tab[k];
        do_reset();
        apb(1'b1, ADDR_CONTROL, {24'h0, 2'(s), 6'h18}, 4'hF, r);
        apb(1'b1, ADDR_DIVIDER, {24'h0, dv}, 4'hF, r);
        n_sel  = 0;
        n_seen = 0;
        repeat (1200) begin
          @(posedge sys_clk_i);
          t = 4'($urandom);
          src_tick_i <= t;
          if (t[s]) begin
            n_sel++;
          end
        end
        @(posedge sys_clk_i);
        src_tick_i <= 4'h0;
        repeat (4) @(posedge sys_clk_i);
        exp_n = (s < 2) ? n_sel / (int'(dv) + 1) : n_sel;
        chk_val("chan_tick_o count", 32'(exp_n), 32'(n_seen));
      end
    end
    conclude();
  end

endmodule
